// File: hdl/gq_cfg.svh
// Purpose: Constants for the pin function and input qualify block
// Assumes: Pins 16..34 are held at indices 0..18
// Notes:   Offsets are Wishbone byte addresses
`ifndef GQ_CFG_SVH
`define GQ_CFG_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define GQ_NPIN       19
`define GQ_NPORTA     16
`define GQ_NGRP       3
`define GQ_GRP_SHIFT  3
`define GQ_PRD_W      8
`define GQ_WIN3       3
`define GQ_WIN6       6
`define GQ_NTRIP      6

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GQ_OFS_AMUX   8'h00
`define GQ_OFS_BMUX   8'h04
`define GQ_OFS_AQSEL  8'h08
`define GQ_OFS_BQSEL  8'h0c
`define GQ_OFS_ACTRL  8'h10
`define GQ_OFS_BCTRL  8'h14
`define GQ_OFS_DOUT   8'h18
`define GQ_OFS_DIR    8'h1c
`define GQ_OFS_DIN    8'h20

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define GQ_RST_MUX    32'h0000_0000
`define GQ_RST_QSEL   32'h0000_0000
`define GQ_RST_CTRL   32'h0000_0000
`define GQ_RST_PIN    19'h0_0000
`define GQ_MASK_A     32'hffff_ffff
`define GQ_MASK_B     32'h0000_003f
`define GQ_MASK_ACTRL 32'h0000_ffff
`define GQ_MASK_BCTRL 32'h0000_00ff
`define GQ_MASK_PIN   32'h0007_ffff

// ----------------------------------------
// Function codes and idle input levels
// ----------------------------------------
`define GQ_FN_GPIO    2'h0
`define GQ_FN_P1      2'h1
`define GQ_FN_P2      2'h2
`define GQ_FN_P3      2'h3
`define GQ_DEF_TRIP   1'b1
`define GQ_DEF_RX     1'b1
`define GQ_DEF_I2C    1'b1
`define GQ_DEF_SYNC   1'b0

// ----------------------------------------
// Pin indices and trip bits
// ----------------------------------------
`define GQ_IX16       0
`define GQ_IX17       1
`define GQ_IX18       2
`define GQ_IX19       3
`define GQ_IX28       12
`define GQ_IX29       13
`define GQ_IX30       14
`define GQ_IX31       15
`define GQ_IX32       16
`define GQ_IX33       17
`define GQ_TRIP1      0
`define GQ_TRIP2      1
`define GQ_TRIP3      2
`define GQ_TRIP4      3
`define GQ_TRIP5      4
`define GQ_TRIP6      5

`endif

// File: hdl/gq_period_div.sv
// Purpose: Sample enable divider for one group of up to eight pins
// Assumes: Period field may change at any time
// Notes:   Pulse every period+1 clocks; zero samples every clock
`timescale 1ns/1ns
`include "gq_cfg.svh"

module gq_period_div (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [`GQ_PRD_W-1:0]  period_i,
	output logic                       en_o
);
	import gq_pkg::*;

	logic [`GQ_PRD_W-1:0] cnt_q;

	// Compare with >= so a lowered period never strands the count
	assign en_o = (cnt_q >= period_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (en_o) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	period_spacing_a: assert property ((en_o && period_i != '0) ##1 $stable(period_i)
		|-> !en_o) else $error("sample enable repeated inside one period");
	period_due_a: assert property ((cnt_q == period_i && $stable(period_i))
		|-> en_o) else $error("sample enable missed at period end");
endmodule // gq_period_div

// File: hdl/gq_pkg.sv
// Purpose: Types shared by the qualify block
// Assumes: Nothing
// Notes:   Enum order follows the two-bit select code
package gq_pkg;
	typedef enum logic [1:0] {
		gq_sync,
		gq_win3,
		gq_win6,
		gq_async
	} gq_qual_t;
endpackage

// File: hdl/gq_qualifier.sv
// Purpose: Input qualification for one pin
// Assumes: sample_i is a one-cycle enable from the group divider
// Notes:   Filtered level starts at zero after reset
`timescale 1ns/1ns
`include "gq_cfg.svh"

module gq_qualifier (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             pin_i,
	input  gq_pkg::gq_qual_t      mode_i,
	input  wire logic             sample_i,
	output logic                  qual_o
);
	import gq_pkg::*;

	logic                  sync1_q;
	logic                  sync2_q;
	logic [`GQ_WIN6-1:0]   hist_q;
	logic                  filt_q;
	logic                  all_one;
	logic                  all_zero;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
		end
	end

	// Window history, only advanced on the group sample enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hist_q <= '0;
		end else if (sample_i) begin
			hist_q <= {hist_q[`GQ_WIN6-2:0], sync2_q};
		end
	end

	always_comb begin
		if (mode_i == gq_win3) begin
			all_one  = &hist_q[`GQ_WIN3-1:0];
			all_zero = ~|hist_q[`GQ_WIN3-1:0];
		end else begin
			all_one  = &hist_q;
			all_zero = ~|hist_q;
		end
	end

	// Mixed window holds the old level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_q <= 1'b0;
		end else if (all_one) begin
			filt_q <= 1'b1;
		end else if (all_zero) begin
			filt_q <= 1'b0;
		end
	end

	always_comb begin
		case (mode_i)
			gq_sync:  qual_o = sync2_q;
			gq_async: qual_o = pin_i;
			default:  qual_o = filt_q;
		endcase
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	win3_rise_a: assert property (($rose(filt_q) && mode_i == gq_win3
		&& $past(mode_i) == gq_win3) |-> &$past(hist_q[`GQ_WIN3-1:0]))
		else $error("three-sample output rose on a mixed window");
	win6_fall_a: assert property (($fell(filt_q) && mode_i == gq_win6
		&& $past(mode_i) == gq_win6) |-> ~|$past(hist_q))
		else $error("six-sample output fell on a mixed window");
	sync_delay_a: assert property ((mode_i == gq_sync) [*3]
		|-> qual_o == $past(pin_i, 2)) else $error("sync path not two flops");
	bypass_path_a: assert property ((mode_i == gq_async) |-> qual_o == pin_i)
		else $error("bypass path not direct");
endmodule // gq_qualifier

// File: hdl/gq_top.sv
// Purpose: Pin function select and input qualification for pins 16..34
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes:   Peripheral inputs and pin drives are registered once at the edge
//
// Functional notes
// - A reserved function code gives no defined pin behaviour and software must avoid it.
// - Each pin has its own two-bit qualify select choosing one of four behaviours.
// - Qualify code 0 synchronises only, and is every pin's setting after reset.
// - Qualify codes 1 and 2 synchronise, then hold until the input stays stable.
// - The sample period is a clock multiple set per group of eight pins.
// - The window spans three or six samples and changes only when all agree.
// - Qualify code 3 passes the pin with no synchronisation.
// - One peripheral input may be fed from more than one pin.
// - An unselected peripheral input rests at its own fixed idle level.
// - Each pin's function comes from a two-bit field in its port mux register.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "gq_cfg.svh"

module gq_top (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic [7:0]              adr_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	input  wire logic                    we_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	output logic                         ack_o,
	input  wire logic [`GQ_NPIN-1:0]     pin_in_i,
	output logic      [`GQ_NPIN-1:0]     pin_out_o,
	output logic      [`GQ_NPIN-1:0]     pin_oe_o,
	input  wire logic                    serial_port_transmit_out_i,
	input  wire logic                    sda_drive_low_i,
	input  wire logic                    scl_drive_low_i,
	input  wire logic                    pwm_sync_output_i,
	input  wire logic                    conversion_start_a_out_i,
	input  wire logic                    conversion_start_b_out_i,
	output logic      [`GQ_NTRIP-1:0]    trip_o,
	output logic                         serial_port_receive_in_o,
	output logic                         sda_in_o,
	output logic                         scl_in_o,
	output logic                         pwm_sync_input_o
);
	import gq_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Two-bit per-pin field; port A low indices then port B high ones share one layout
	function automatic logic [1:0] pin_field(input logic [31:0] a, input logic [31:0] b,
		input int idx);
		logic [31:0] w;
		int          k;
		w = (idx < `GQ_NPORTA) ? a : b;
		k = (idx < `GQ_NPORTA) ? idx : idx - `GQ_NPORTA;
		return w[2*k +: 2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r & mask;
	endfunction

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [31:0]          amux_q;
	logic [31:0]          bmux_q;
	logic [31:0]          aqsel_q;
	logic [31:0]          bqsel_q;
	logic [31:0]          actrl_q;
	logic [31:0]          bctrl_q;
	logic [`GQ_NPIN-1:0]  dout_q;
	logic [`GQ_NPIN-1:0]  dir_q;
	logic [`GQ_NPIN-1:0]  qual_w;
	logic [`GQ_NGRP-1:0]  smp_en;
	logic                 ack_q;
	logic [31:0]          dat_q;
	logic [31:0]          rd_d;
	logic                 req;
	logic                 wr;
	logic [7:0]           wadr;

	assign req  = cyc_i && stb_i;
	assign wr   = req && we_i && ack_q;
	assign wadr = {adr_i[7:2], 2'b00};
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// One wait state; write lands on the edge the master sees ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	always_comb begin
		case (wadr)
			`GQ_OFS_AMUX:  rd_d = amux_q;
			`GQ_OFS_BMUX:  rd_d = bmux_q;
			`GQ_OFS_AQSEL: rd_d = aqsel_q;
			`GQ_OFS_BQSEL: rd_d = bqsel_q;
			`GQ_OFS_ACTRL: rd_d = actrl_q;
			`GQ_OFS_BCTRL: rd_d = bctrl_q;
			`GQ_OFS_DOUT:  rd_d = 32'(dout_q);
			`GQ_OFS_DIR:   rd_d = 32'(dir_q);
			`GQ_OFS_DIN:   rd_d = 32'(qual_w);
			default:       rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (req && !ack_q) begin
			dat_q <= rd_d;
		end
	end

	// Function select registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			amux_q <= `GQ_RST_MUX;
			bmux_q <= `GQ_RST_MUX;
		end else if (wr && wadr == `GQ_OFS_AMUX) begin
			amux_q <= merge(amux_q, dat_i, sel_i, `GQ_MASK_A);
		end else if (wr && wadr == `GQ_OFS_BMUX) begin
			bmux_q <= merge(bmux_q, dat_i, sel_i, `GQ_MASK_B);
		end
	end

	// Qualify select and period registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aqsel_q <= `GQ_RST_QSEL;
			bqsel_q <= `GQ_RST_QSEL;
			actrl_q <= `GQ_RST_CTRL;
			bctrl_q <= `GQ_RST_CTRL;
		end else if (wr) begin
			case (wadr)
				`GQ_OFS_AQSEL: aqsel_q <= merge(aqsel_q, dat_i, sel_i, `GQ_MASK_A);
				`GQ_OFS_BQSEL: bqsel_q <= merge(bqsel_q, dat_i, sel_i, `GQ_MASK_B);
				`GQ_OFS_ACTRL: actrl_q <= merge(actrl_q, dat_i, sel_i, `GQ_MASK_ACTRL);
				`GQ_OFS_BCTRL: bctrl_q <= merge(bctrl_q, dat_i, sel_i, `GQ_MASK_BCTRL);
				default: ;
			endcase
		end
	end

	// Plain I/O data and direction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dout_q <= `GQ_RST_PIN;
			dir_q  <= `GQ_RST_PIN;
		end else if (wr && wadr == `GQ_OFS_DOUT) begin
			dout_q <= `GQ_NPIN'(merge(32'(dout_q), dat_i, sel_i, `GQ_MASK_PIN));
		end else if (wr && wadr == `GQ_OFS_DIR) begin
			dir_q <= `GQ_NPIN'(merge(32'(dir_q), dat_i, sel_i, `GQ_MASK_PIN));
		end
	end

	// ----------------------------------------
	// Qualification
	// ----------------------------------------
	logic [`GQ_PRD_W-1:0] prd [`GQ_NGRP];

	assign prd[0] = actrl_q[`GQ_PRD_W-1:0];
	assign prd[1] = actrl_q[2*`GQ_PRD_W-1:`GQ_PRD_W];
	assign prd[2] = bctrl_q[`GQ_PRD_W-1:0];

	for (genvar g = 0; g < `GQ_NGRP; g++) begin : g_div
		gq_period_div u_div (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.period_i (prd[g]),
			.en_o     (smp_en[g])
		);
	end

	for (genvar p = 0; p < `GQ_NPIN; p++) begin : g_pin
		gq_qualifier u_qual (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.pin_i    (pin_in_i[p]),
			.mode_i   (gq_qual_t'(pin_field(aqsel_q, bqsel_q, p))),
			.sample_i (smp_en[p >> `GQ_GRP_SHIFT]),
			.qual_o   (qual_w[p])
		);
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	logic [`GQ_NPIN-1:0] pout_d;
	logic [`GQ_NPIN-1:0] poe_d;

	always_comb begin
		pout_d = dout_q;
		poe_d  = dir_q;
		// Reserved and input functions float the pin: safest undefined choice
		for (int i = 0; i < `GQ_NPIN; i++) begin
			if (pin_field(amux_q, bmux_q, i) != `GQ_FN_GPIO) begin
				pout_d[i] = 1'b0;
				poe_d[i]  = 1'b0;
			end
		end
		if (pin_field(amux_q, bmux_q, `GQ_IX29) == `GQ_FN_P1) begin
			pout_d[`GQ_IX29] = serial_port_transmit_out_i;
			poe_d[`GQ_IX29]  = 1'b1;
		end
		case (pin_field(amux_q, bmux_q, `GQ_IX32))
			`GQ_FN_P1: poe_d[`GQ_IX32] = sda_drive_low_i;
			`GQ_FN_P3: begin
				pout_d[`GQ_IX32] = conversion_start_a_out_i;
				poe_d[`GQ_IX32]  = 1'b1;
			end
			default: ;
		endcase
		case (pin_field(amux_q, bmux_q, `GQ_IX33))
			`GQ_FN_P1: poe_d[`GQ_IX33] = scl_drive_low_i;
			`GQ_FN_P2: begin
				pout_d[`GQ_IX33] = pwm_sync_output_i;
				poe_d[`GQ_IX33]  = 1'b1;
			end
			`GQ_FN_P3: begin
				pout_d[`GQ_IX33] = conversion_start_b_out_i;
				poe_d[`GQ_IX33]  = 1'b1;
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_out_o <= '0;
			pin_oe_o  <= '0;
		end else begin
			pin_out_o <= pout_d;
			pin_oe_o  <= poe_d;
		end
	end

	// ----------------------------------------
	// Peripheral input routing
	// ----------------------------------------
	logic [`GQ_NTRIP-1:0] trip_d;
	logic                 rx_d;
	logic                 sda_d;
	logic                 scl_d;
	logic                 sync_d;

	// Later assignment wins: lower pin has priority on shared inputs
	always_comb begin
		trip_d = {`GQ_NTRIP{`GQ_DEF_TRIP}};
		rx_d   = `GQ_DEF_RX;
		sda_d  = `GQ_DEF_I2C;
		scl_d  = `GQ_DEF_I2C;
		sync_d = `GQ_DEF_SYNC;
		if (pin_field(amux_q, bmux_q, `GQ_IX18) == `GQ_FN_P3) trip_d[`GQ_TRIP1] = qual_w[`GQ_IX18];
		if (pin_field(amux_q, bmux_q, `GQ_IX19) == `GQ_FN_P3) trip_d[`GQ_TRIP2] = qual_w[`GQ_IX19];
		if (pin_field(amux_q, bmux_q, `GQ_IX30) == `GQ_FN_P3) trip_d[`GQ_TRIP3] = qual_w[`GQ_IX30];
		if (pin_field(amux_q, bmux_q, `GQ_IX31) == `GQ_FN_P3) trip_d[`GQ_TRIP4] = qual_w[`GQ_IX31];
		if (pin_field(amux_q, bmux_q, `GQ_IX28) == `GQ_FN_P3) trip_d[`GQ_TRIP5] = qual_w[`GQ_IX28];
		if (pin_field(amux_q, bmux_q, `GQ_IX16) == `GQ_FN_P3) trip_d[`GQ_TRIP5] = qual_w[`GQ_IX16];
		if (pin_field(amux_q, bmux_q, `GQ_IX29) == `GQ_FN_P3) trip_d[`GQ_TRIP6] = qual_w[`GQ_IX29];
		if (pin_field(amux_q, bmux_q, `GQ_IX17) == `GQ_FN_P3) trip_d[`GQ_TRIP6] = qual_w[`GQ_IX17];
		if (pin_field(amux_q, bmux_q, `GQ_IX28) == `GQ_FN_P1) rx_d = qual_w[`GQ_IX28];
		if (pin_field(amux_q, bmux_q, `GQ_IX32) == `GQ_FN_P1) sda_d = qual_w[`GQ_IX32];
		if (pin_field(amux_q, bmux_q, `GQ_IX33) == `GQ_FN_P1) scl_d = qual_w[`GQ_IX33];
		if (pin_field(amux_q, bmux_q, `GQ_IX32) == `GQ_FN_P2) sync_d = qual_w[`GQ_IX32];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trip_o                   <= {`GQ_NTRIP{`GQ_DEF_TRIP}};
			serial_port_receive_in_o <= `GQ_DEF_RX;
			sda_in_o                 <= `GQ_DEF_I2C;
			scl_in_o                 <= `GQ_DEF_I2C;
			pwm_sync_input_o         <= `GQ_DEF_SYNC;
		end else begin
			trip_o                   <= trip_d;
			serial_port_receive_in_o <= rx_d;
			sda_in_o                 <= sda_d;
			scl_in_o                 <= scl_d;
			pwm_sync_input_o         <= sync_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence bus_new_req;
		req && !ack_q;
	endsequence
	sequence bus_answer;
		ack_q ##1 !ack_q;
	endsequence

	bus_ack_once_a: assert property (bus_new_req |=> bus_answer)
		else $error("ack not a single cycle after request");
	mux_reset_a: assert property ($past(rst_i) |-> amux_q == `GQ_RST_MUX
		&& bmux_q == `GQ_RST_MUX) else $error("function fields not I/O after reset");
	qsel_reset_a: assert property ($past(rst_i) |-> aqsel_q == `GQ_RST_QSEL
		&& bqsel_q == `GQ_RST_QSEL) else $error("qualify select not sync after reset");
	trip_idle_a: assert property ((pin_field(amux_q, bmux_q, `GQ_IX18) != `GQ_FN_P3)
		|=> trip_o[`GQ_TRIP1] == `GQ_DEF_TRIP) else $error("unselected trip input not idle");
	trip_share_a: assert property ((pin_field(amux_q, bmux_q, `GQ_IX16) == `GQ_FN_P3)
		|=> trip_o[`GQ_TRIP5] == $past(qual_w[`GQ_IX16])) else $error("trip five not from pin 16");
	tx_route_a: assert property ((pin_field(amux_q, bmux_q, `GQ_IX29) == `GQ_FN_P1)
		|=> pin_out_o[`GQ_IX29] == $past(serial_port_transmit_out_i) && pin_oe_o[`GQ_IX29])
		else $error("serial transmit not on pin 29");
	fn_float_a: assert property ((pin_field(amux_q, bmux_q, `GQ_IX16) != `GQ_FN_GPIO)
		|=> !pin_oe_o[`GQ_IX16]) else $error("pin 16 driven outside I/O mode");
endmodule // gq_top

// File: verification/gq_board_model.sv
// Purpose: Board side of pins 16..34 as seen by the qualify block
// Assumes: Every pin carries a board pull-up
// Notes:   A released pin goes to its pull-up, not to its last level
`timescale 1ns/1ns
`include "gq_cfg.svh"

module gq_board_model (
	input  wire logic [`GQ_NPIN-1:0] lvl_i,
	input  wire logic [`GQ_NPIN-1:0] drv_en_i,
	input  wire logic [`GQ_NPIN-1:0] pin_out_i,
	input  wire logic [`GQ_NPIN-1:0] pin_oe_i,
	output logic      [`GQ_NPIN-1:0] pin_o
);
	// Board lets go wherever the device drives, so no contention
	always_comb begin
		for (int i = 0; i < `GQ_NPIN; i++) begin
			pin_o[i] = pin_oe_i[i] ? pin_out_i[i] : (drv_en_i[i] ? lvl_i[i] : 1'b1);
		end
	end
endmodule // gq_board_model

// File: verification/gq_top_tb_top.sv
// Purpose: Self-checking bench for pin function select and qualify
// Assumes: Only defined function codes are ever programmed
// Notes:   Pin and output checks sampled one step after the clock edge; bus reads at the edge
`timescale 1ns/1ns
`include "gq_cfg.svh"

module gq_top_tb_top;
	import gq_pkg::*;
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic [7:0]           adr_i = 8'h00;
	logic [31:0]          dat_i = 32'h0;
	logic [31:0]          dat_o;
	logic                 we_i  = 1'b0;
	logic [3:0]           sel_i = 4'h0;
	logic                 cyc_i = 1'b0;
	logic                 stb_i = 1'b0;
	logic                 ack_o;
	logic [`GQ_NPIN-1:0]  pin_in, pin_out, pin_oe;
	logic [`GQ_NPIN-1:0]  lvl    = '0;
	logic [`GQ_NPIN-1:0]  drv_en = '1;
	logic                 tx = 1'b0;
	logic                 sda_dl = 1'b0;
	logic                 conv_b = 1'b0;
	logic [`GQ_NTRIP-1:0] trip;
	logic                 rx, sda_in, scl_in, sync_in;
	int                   mismatches = 0;
	int                   compares = 0;

	always #25 clk_i = ~clk_i;

	gq_board_model board (.lvl_i(lvl), .drv_en_i(drv_en), .pin_out_i(pin_out),
		.pin_oe_i(pin_oe), .pin_o(pin_in));

	gq_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
		.we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
		.serial_port_transmit_out_i(tx), .sda_drive_low_i(sda_dl), .scl_drive_low_i(1'b0),
		.pwm_sync_output_i(1'b0), .conversion_start_a_out_i(1'b0),
		.conversion_start_b_out_i(conv_b), .trip_o(trip), .serial_port_receive_in_o(rx),
		.sda_in_o(sda_in), .scl_in_o(scl_in), .pwm_sync_input_o(sync_in));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic report_and_stop();
		if (mismatches == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask

	// Holds the request until ack is seen; bounded wait
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n = 0;
		@(posedge clk_i);
		adr_i <= a;
		we_i  <= w;
		dat_i <= d;
		sel_i <= s;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		if (ack_o !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		logic [31:0] q;
		wb(a, 1'b1, d, s, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(a, 1'b0, 32'h0, 4'hf, q);
		cmp(q, exp);
	endtask

	task automatic look(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic drive_pin(input int i, input logic v);
		@(posedge clk_i);
		lvl[i] <= v;
	endtask

	initial begin
		#2_000_000;
		mismatches++;
		report_and_stop();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`GQ_OFS_AMUX, 32'h0);
		rd(`GQ_OFS_BMUX, 32'h0);
		rd(`GQ_OFS_AQSEL, 32'h0);
		rd(`GQ_OFS_BQSEL, 32'h0);
		cmp({26'h0, trip}, 32'h3f);
		cmp({rx, sda_in, scl_in, sync_in}, 32'he);
		cmp({13'h0, pin_oe}, 32'h0);
		// Masked fields and byte lanes; unmapped place is inert
		wr(`GQ_OFS_BMUX, 32'hffff_ffc5);
		rd(`GQ_OFS_BMUX, 32'h05);
		wr(`GQ_OFS_ACTRL, 32'h1234_5678, 4'b0010);
		rd(`GQ_OFS_ACTRL, 32'h5600);
		wr(8'h24, 32'hffff_ffff);
		rd(8'h24, 32'h0);
		// Open-drain data pin pulls its own input low
		drive_pin(16, 1'b1);
		look(4);
		cmp1(sda_in, 1'b1);
		@(posedge clk_i);
		sda_dl <= 1'b1;
		look(5);
		cmp({pin_oe[16], pin_out[16], sda_in}, 32'h4);
		// Serial pins, sync-only and bypass latency
		wr(`GQ_OFS_AMUX, 32'h0500_0000);
		drive_pin(12, 1'b1);
		look(2);
		cmp1(rx, 1'b0);
		look(1);
		cmp1(rx, 1'b1);
		@(posedge clk_i);
		tx <= 1'b1;
		look(1);
		cmp({pin_oe[13], pin_out[13]}, 32'h3);
		wr(`GQ_OFS_AQSEL, 32'h0300_0000);
		drive_pin(12, 1'b0);
		look(1);
		cmp1(rx, 1'b0);
		// Three-sample window, interval 4 clocks for pins 24..31
		wr(`GQ_OFS_ACTRL, 32'h0000_0300);
		wr(`GQ_OFS_AQSEL, 32'h0100_0000);
		look(30);
		drive_pin(12, 1'b1);
		repeat (4) @(posedge clk_i);
		lvl[12] <= 1'b0;
		look(40);
		cmp1(rx, 1'b0);
		drive_pin(12, 1'b1);
		look(7);
		cmp1(rx, 1'b0);
		look(21);
		cmp1(rx, 1'b1);
		// Six-sample window rejects three agreeing samples
		wr(`GQ_OFS_AQSEL, 32'h0200_0000);
		drive_pin(12, 1'b0);
		repeat (12) @(posedge clk_i);
		lvl[12] <= 1'b1;
		look(50);
		cmp1(rx, 1'b1);
		drive_pin(12, 1'b0);
		look(19);
		cmp1(rx, 1'b1);
		look(21);
		cmp1(rx, 1'b0);
		// One trip input fed from two pins, then idle
		// Pin 16 low, pin 28 high: only pin 16 is told apart from idle; pin 28 matches the idle high
		wr(`GQ_OFS_AQSEL, 32'h0);
		drive_pin(12, 1'b1);
		wr(`GQ_OFS_AMUX, 32'h0300_0003);
		look(5);
		cmp1(trip[`GQ_TRIP5], 1'b0);
		wr(`GQ_OFS_AMUX, 32'h0300_0000);
		look(5);
		cmp1(trip[`GQ_TRIP5], 1'b1);
		wr(`GQ_OFS_AMUX, 32'h0000_0003);
		look(5);
		cmp1(trip[`GQ_TRIP5], 1'b0);
		wr(`GQ_OFS_AMUX, 32'h0);
		look(5);
		cmp1(trip[`GQ_TRIP5], 1'b1);
		// Sync input and conversion start on port B
		wr(`GQ_OFS_BMUX, 32'h0000_000e);
		conv_b <= 1'b1;
		look(4);
		cmp({pin_oe[17], pin_out[17], sync_in}, 32'h7);
		wr(`GQ_OFS_BMUX, 32'h0);
		look(4);
		cmp({pin_oe[17], sync_in}, 32'h0);
		// Plain I/O drive and qualified input readback
		wr(`GQ_OFS_DIR, 32'h0000_0002);
		wr(`GQ_OFS_DOUT, 32'hffff_fff2);
		look(3);
		cmp({pin_oe[1], pin_out[1], pin_oe[0]}, 32'h6);
		rd(`GQ_OFS_DIN, 32'h0001_1002);
		report_and_stop();
	end
endmodule // gq_top_tb_top
